// *** pcp_pkg.sv ***
// Package for the clock configuration and protection block.
// Assumes an 8-bit register port with a 10-bit byte address.

package pcp_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [9:0] ADDR_SYNTH = 10'h2f0;
	localparam logic [9:0] ADDR_REF_DIVIDER = 10'h2f1;
	localparam logic [9:0] ADDR_POST_DIVIDER = 10'h2f2;
	localparam logic [9:0] ADDR_CLKSEL = 10'h2f3;
	localparam logic [9:0] ADDR_PLLCTL = 10'h2f4;
	localparam logic [9:0] ADDR_TRIM_HI = 10'h2f5;
	localparam logic [9:0] ADDR_TRIM_LO = 10'h2f6;
	localparam logic [9:0] ADDR_STATUS = 10'h2f7;
	localparam logic [9:0] ADDR_OSC_CFG = 10'h2fa;
	localparam logic [9:0] ADDR_CONFIG_PROTECT_BIT_KEY = 10'h2fb;
	localparam logic [9:0] ADDR_TEST = 10'h2fc;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OSC_EN_BIT = 7;
	localparam int OSC_BW_BIT = 6;
	localparam int PINS_RES_BIT = 5;
	localparam int PLL_SOURCE_SELECT_BIT = 7;
	localparam int CONFIG_PROTECT_BIT_BIT = 0;
	localparam int LVR_LSB = 3;
	localparam int ACLK_EN_BIT = 0;
	localparam int LOCK_BIT = 0;
	localparam int OSC_UP_BIT = 1;

	// ------------------------------------------------------------
	// Keys and values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] CONFIG_PROTECT_BIT_UNLOCK_KEY = 8'h26;
	localparam logic [7:0] TEST_UNLOCK_KEY = 8'he3;
	localparam logic [5:0] SYNTH_RST = 6'h1f;
	localparam logic [3:0] REF_DIVIDER_RST = 4'h0;
	localparam logic [4:0] POST_DIVIDER_RST = 5'h03;
	localparam logic PLL_SOURCE_SELECT_RST = 1'b1;
	localparam logic CONFIG_PROTECT_BIT_RST = 1'b0;
	localparam logic [7:0] TEST_RST = 8'h00;
	localparam logic [7:0] TRIM_HI_RST = 8'h00;
	localparam logic [7:0] TRIM_LO_RST = 8'h00;

	// ------------------------------------------------------------
	// Frequencies (kHz) and cycle counts
	// ------------------------------------------------------------
	localparam logic [15:0] IRC_FREQ_KHZ = 16'h03e8;
	localparam logic [3:0] OSC_QUAL_EDGES = 4'hf;

	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pcp_bus_req_t;

	typedef struct packed {
		logic [15:0] ref_khz;
		logic [23:0] vco_khz;
		logic [23:0] pll_khz;
		logic [23:0] bus_khz;
	} pcp_freq_t;

endpackage

// *** pcp_top.sv ***
// Clock configuration: oscillator setup, write protection key,
// factory test register and divider arithmetic in kHz.
// Assumes a synchronous 8-bit register master on core_clk; the
// crystal clock, tolerance flag, special mode and supply status
// arrive from other domains and are synchronised here.


`timescale 1ns/1ps
`default_nettype none

module pcp_top
	import pcp_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire pcp_pkg::pcp_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic crystal_in_pin,
	input wire logic [15:0] crystal_freq_khz,
	input wire logic pll_in_tolerance,
	input wire logic special_mode,
	input wire logic [2:0] supply_lvr_status,
	input wire logic periodic_irq_enable,
	input wire logic periodic_irq_ext_access,
	input wire logic periodic_irq_clock,
	output logic osc_start,
	output logic clock_monitor_en,
	output logic crystal_pins_reserved,
	output logic filtered_crystal_clock,
	output logic osc_up_status,
	output logic pll_locked,
	output logic pll_source_select,
	output logic auto_clock_pin_out,
	output pcp_pkg::pcp_freq_t freq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic osc_enable;
		logic osc_filter_bandwidth;
		logic [4:0] osc_filter_ratio;
		logic pins_reserved;
		logic config_protect_bit;
		logic test_unlocked;
		logic auto_clock_pin_out_en;
		logic [5:0] synth_multiplier;
		logic [3:0] ref_divider;
		logic [4:0] post_divider;
		logic pll_source_select;
		logic [7:0] pll_ctl;
		logic [7:0] trim_hi;
		logic [7:0] trim_lo;
		logic xin_s1;
		logic xin_s2;
		logic tol_s1;
		logic tol_s2;
		logic spm_s1;
		logic spm_s2;
		logic [2:0] lvr_s1;
		logic [2:0] lvr_s2;
		logic [1:0] xin_hist;
		logic xclk_filt;
		logic [3:0] qual_cnt;
		logic osc_up;
		logic lock;
		logic aclk_out;
		logic [7:0] rdata;
		pcp_freq_t freq;
	} pcp_state_t;

	pcp_state_t state_ff;
	pcp_state_t nxt_state;

	// Division helper; a zero divisor cannot occur since every
	// divider is a field value plus one.
	function automatic logic [23:0] div_plus_one(
		input logic [23:0] num,
		input logic [5:0] field
	);
		logic [23:0] den;
		den = {18'h0, field} + 24'h1;
		div_plus_one = num / den;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic wr_hit;
		logic rd_hit;
		logic unprot;
		logic osc_wr;
		logic filt_on;
		logic spike;
		logic xin_rise;
		logic [15:0] ref_khz;
		logic [23:0] vco_khz;
		logic [23:0] pll_khz;
		logic [29:0] vco_wide;
		logic [7:0] rd_val;

		nxt_state = state_ff;
		wr_hit = bus_req.wr;
		rd_hit = bus_req.rd;
		unprot = !state_ff.config_protect_bit;
		osc_wr = 1'b0;
		rd_val = 8'h00;
		filt_on = 1'b0;
		spike = 1'b0;
		xin_rise = 1'b0;
		ref_khz = 16'h0000;
		vco_khz = 24'h000000;
		pll_khz = 24'h000000;
		vco_wide = 30'h00000000;

		// Two-stage synchronisers for inputs from other domains
		nxt_state.xin_s1 = crystal_in_pin;
		nxt_state.xin_s2 = state_ff.xin_s1;
		nxt_state.tol_s1 = pll_in_tolerance;
		nxt_state.tol_s2 = state_ff.tol_s1;
		nxt_state.spm_s1 = special_mode;
		nxt_state.spm_s2 = state_ff.spm_s1;
		nxt_state.lvr_s1 = supply_lvr_status;
		nxt_state.lvr_s2 = state_ff.lvr_s1;

		// Register writes
		if (wr_hit) begin
			case (bus_req.addr)
			ADDR_SYNTH: begin
				if (unprot) begin
					nxt_state.synth_multiplier = bus_req.wdata[5:0];
				end
			end
			ADDR_REF_DIVIDER: begin
				if (unprot) begin
					nxt_state.ref_divider = bus_req.wdata[3:0];
				end
			end
			ADDR_POST_DIVIDER: begin
				nxt_state.post_divider = bus_req.wdata[4:0];
			end
			ADDR_CLKSEL: begin
				if (unprot) begin
					nxt_state.pll_source_select =
						bus_req.wdata[PLL_SOURCE_SELECT_BIT];
				end
			end
			ADDR_PLLCTL: begin
				if (unprot) begin
					nxt_state.pll_ctl = bus_req.wdata;
				end
			end
			ADDR_TRIM_HI: begin
				if (unprot) begin
					nxt_state.trim_hi = bus_req.wdata;
				end
			end
			ADDR_TRIM_LO: begin
				if (unprot) begin
					nxt_state.trim_lo = bus_req.wdata;
				end
			end
			ADDR_OSC_CFG: begin
				// Only writable while running from the PLL
				if (unprot && state_ff.pll_source_select) begin
					osc_wr = 1'b1;
					nxt_state.osc_enable =
						bus_req.wdata[OSC_EN_BIT];
					nxt_state.osc_filter_bandwidth =
						bus_req.wdata[OSC_BW_BIT];
					nxt_state.osc_filter_ratio =
						bus_req.wdata[4:0];
				end
			end
			ADDR_CONFIG_PROTECT_BIT_KEY: begin
				nxt_state.config_protect_bit =
					(bus_req.wdata != CONFIG_PROTECT_BIT_UNLOCK_KEY);
			end
			ADDR_TEST: begin
				// Unlock write itself stores nothing
				if (state_ff.spm_s2) begin
					if (state_ff.test_unlocked) begin
						nxt_state.auto_clock_pin_out_en =
							bus_req.wdata[ACLK_EN_BIT];
					end else if (bus_req.wdata == TEST_UNLOCK_KEY) begin
						nxt_state.test_unlocked = 1'b1;
					end
				end
			end
			default: begin
			end
			endcase
		end

		// Pin reservation sticks until reset
		if (state_ff.osc_enable) begin
			nxt_state.pins_reserved = 1'b1;
		end

		// ------------------------------------------------------------
		// Adaptive filter and qualification
		// ------------------------------------------------------------
		filt_on = (state_ff.osc_filter_ratio != 5'h00);
		nxt_state.xin_hist = {state_ff.xin_hist[0], state_ff.xin_s2};
		// A level that lasts a single sample is treated as a spike
		spike = (state_ff.xin_hist[0] != state_ff.xin_hist[1]) &&
			(state_ff.xin_s2 == state_ff.xin_hist[1]);
		if (filt_on) begin
			// Follow the input only once two samples agree
			if (state_ff.xin_s2 == state_ff.xin_hist[0]) begin
				nxt_state.xclk_filt = state_ff.xin_s2;
			end
		end else begin
			nxt_state.xclk_filt = state_ff.xin_s2;
		end
		xin_rise = nxt_state.xclk_filt && !state_ff.xclk_filt;

		if (!state_ff.osc_enable || osc_wr) begin
			nxt_state.qual_cnt = 4'h0;
			nxt_state.osc_up = 1'b0;
		end else if (filt_on && (spike || !state_ff.lock)) begin
			// Noise or lost lock drops qualification
			nxt_state.qual_cnt = 4'h0;
			nxt_state.osc_up = 1'b0;
		end else if (xin_rise) begin
			if (state_ff.qual_cnt == OSC_QUAL_EDGES) begin
				nxt_state.osc_up = 1'b1;
			end else begin
				nxt_state.qual_cnt = state_ff.qual_cnt + 4'h1;
			end
		end

		// Lock follows the tolerance flag; an oscillator config write drops it
		nxt_state.lock = state_ff.tol_s2 && !osc_wr;

		// ------------------------------------------------------------
		// Interrupt clock routing
		// ------------------------------------------------------------
		nxt_state.aclk_out = periodic_irq_clock &&
			state_ff.auto_clock_pin_out_en &&
			periodic_irq_enable &&
			!periodic_irq_ext_access;

		// ------------------------------------------------------------
		// Divider arithmetic
		// ------------------------------------------------------------
		if (state_ff.osc_enable) begin
			ref_khz = 16'(div_plus_one({8'h0, crystal_freq_khz},
				{2'b00, state_ff.ref_divider}));
		end else begin
			ref_khz = IRC_FREQ_KHZ;
		end
		vco_wide = 30'(ref_khz) * 30'({state_ff.synth_multiplier} + 7'h1);
		vco_khz = {vco_wide[22:0], 1'b0};
		if (state_ff.lock) begin
			pll_khz = div_plus_one(vco_khz,
				{1'b0, state_ff.post_divider});
		end else begin
			pll_khz = vco_khz >> 2;
		end
		nxt_state.freq.ref_khz = ref_khz;
		nxt_state.freq.vco_khz = vco_khz;
		nxt_state.freq.pll_khz = pll_khz;
		if (state_ff.pll_source_select) begin
			nxt_state.freq.bus_khz = pll_khz >> 1;
		end else if (state_ff.osc_enable) begin
			nxt_state.freq.bus_khz = {8'h0, crystal_freq_khz};
		end else begin
			nxt_state.freq.bus_khz = {8'h0, IRC_FREQ_KHZ};
		end

		// ------------------------------------------------------------
		// Register reads, answered one cycle later
		// ------------------------------------------------------------
		if (rd_hit) begin
			case (bus_req.addr)
			ADDR_SYNTH: rd_val = {2'b00, state_ff.synth_multiplier};
			ADDR_REF_DIVIDER: rd_val = {4'h0, state_ff.ref_divider};
			ADDR_POST_DIVIDER: rd_val = {3'b000, state_ff.post_divider};
			ADDR_CLKSEL: begin
				rd_val[PLL_SOURCE_SELECT_BIT] = state_ff.pll_source_select;
			end
			ADDR_PLLCTL: rd_val = state_ff.pll_ctl;
			ADDR_TRIM_HI: rd_val = state_ff.trim_hi;
			ADDR_TRIM_LO: rd_val = state_ff.trim_lo;
			ADDR_STATUS: begin
				rd_val[LOCK_BIT] = state_ff.lock;
				rd_val[OSC_UP_BIT] = state_ff.osc_up;
			end
			ADDR_OSC_CFG: begin
				rd_val[OSC_EN_BIT] = state_ff.osc_enable;
				rd_val[OSC_BW_BIT] = state_ff.osc_filter_bandwidth;
				rd_val[PINS_RES_BIT] = state_ff.pins_reserved;
				rd_val[4:0] = state_ff.osc_filter_ratio;
			end
			ADDR_CONFIG_PROTECT_BIT_KEY: begin
				rd_val[CONFIG_PROTECT_BIT_BIT] = state_ff.config_protect_bit;
			end
			ADDR_TEST: begin
				rd_val[LVR_LSB +: 3] = state_ff.lvr_s2;
				rd_val[ACLK_EN_BIT] = state_ff.auto_clock_pin_out_en;
			end
			default: rd_val = 8'h00;
			endcase
		end
		nxt_state.rdata = rd_val;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
			state_ff.synth_multiplier <= SYNTH_RST;
			state_ff.ref_divider <= REF_DIVIDER_RST;
			state_ff.post_divider <= POST_DIVIDER_RST;
			state_ff.pll_source_select <= PLL_SOURCE_SELECT_RST;
			state_ff.config_protect_bit <= CONFIG_PROTECT_BIT_RST;
			state_ff.auto_clock_pin_out_en <= TEST_RST[ACLK_EN_BIT];
			state_ff.trim_hi <= TRIM_HI_RST;
			state_ff.trim_lo <= TRIM_LO_RST;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all taken from the state register
	// ------------------------------------------------------------
	assign bus_rdata = state_ff.rdata;
	assign osc_start = state_ff.osc_enable;
	assign clock_monitor_en = state_ff.osc_enable;
	assign crystal_pins_reserved = state_ff.pins_reserved;
	assign filtered_crystal_clock = state_ff.xclk_filt;
	assign osc_up_status = state_ff.osc_up;
	assign pll_locked = state_ff.lock;
	assign pll_source_select = state_ff.pll_source_select;
	assign auto_clock_pin_out = state_ff.aclk_out;
	assign freq = state_ff.freq;

endmodule

`default_nettype wire

// *** pcp_props.sv ***
// Port checker for the clock configuration block.
// Assumes binding to pcp_top with all port names unchanged.
`timescale 1ns/1ps
`default_nettype none
module pcp_props
	import pcp_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire pcp_pkg::pcp_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic pll_in_tolerance,
	input wire logic periodic_irq_enable,
	input wire logic periodic_irq_ext_access,
	input wire logic osc_start,
	input wire logic crystal_pins_reserved,
	input wire logic osc_up_status,
	input wire logic pll_locked,
	input wire logic pll_source_select,
	input wire logic auto_clock_pin_out,
	input wire pcp_pkg::pcp_freq_t freq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	chk_key_clears: assert property (clk_en && bus_req.wr &&
		bus_req.addr == ADDR_CONFIG_PROTECT_BIT_KEY && bus_req.wdata == CONFIG_PROTECT_BIT_UNLOCK_KEY
		##1 clk_en && bus_req.rd && bus_req.addr == ADDR_CONFIG_PROTECT_BIT_KEY
		|=> !bus_rdata[CONFIG_PROTECT_BIT_BIT]) else $error("key did not clear");
	chk_key_sets: assert property (clk_en && bus_req.wr &&
		bus_req.addr == ADDR_CONFIG_PROTECT_BIT_KEY && bus_req.wdata != CONFIG_PROTECT_BIT_UNLOCK_KEY
		##1 clk_en && bus_req.rd && bus_req.addr == ADDR_CONFIG_PROTECT_BIT_KEY
		|=> bus_rdata[CONFIG_PROTECT_BIT_BIT]) else $error("key did not set");
	chk_pins_sticky: assert property ($past(crystal_pins_reserved)
		|-> crystal_pins_reserved) else $error("pin reservation lost");
	chk_pins_follow: assert property (clk_en && osc_start
		|=> crystal_pins_reserved) else $error("pins not reserved");
	chk_lock_tol: assert property ((clk_en && !pll_in_tolerance)[*4]
		|-> !pll_locked) else $error("lock outside tolerance");
	chk_up_osc: assert property (osc_up_status
		|-> $past(osc_start)) else $error("osc up while disabled");
	chk_bus_half: assert property (pll_source_select[*2]
		|-> freq.bus_khz == freq.pll_khz >> 1) else $error("bus not half");
	chk_pll_quarter: assert property ((!pll_locked)[*3]
		|-> freq.pll_khz == freq.vco_khz >> 2) else $error("pll not quarter");
	// Three cycles, since freq still shows zero one edge after reset
	chk_ref_irc: assert property ((!osc_start)[*3]
		|-> freq.ref_khz == IRC_FREQ_KHZ) else $error("ref not internal");
	chk_aclk_gate: assert property (clk_en &&
		!(periodic_irq_enable && !periodic_irq_ext_access)
		|=> !auto_clock_pin_out) else $error("clock routed while gated");
endmodule
bind pcp_top pcp_props chk (.*);
`default_nettype wire

// *** pcp_crystal_out_pin_model.sv ***
// Crystal oscillator model driving the crystal pin.
// Assumes run follows the block's oscillator start output.
`timescale 1ns/1ps
`default_nettype none
module pcp_crystal_out_pin_model #(
	parameter int HALF_NS = 125,
	parameter logic [15:0] FREQ_KHZ = 16'h0fa0
) (
	input wire logic run,
	input wire logic spike,
	output logic crystal_in_pin,
	output logic [15:0] crystal_freq_khz
);
	logic osc_q = 1'b0;
	// A stopped crystal rests low; it only swings once started
	always #(HALF_NS) osc_q = run ? !osc_q : 1'b0;
	// Glitch flips the level for one core cycle only
	assign crystal_in_pin = osc_q ^ spike;
	assign crystal_freq_khz = FREQ_KHZ;
endmodule
`default_nettype wire

// *** tb_pll_clock_config_protect.sv ***
// Self-checking bench for the clock configuration block.
// Assumes pcp_top, its package, the checker and crystal model.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_clock_config_protect;
	import pcp_pkg::*;
	typedef struct packed {logic w; logic [9:0] a; logic [7:0] d;} pcp_row_t;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	pcp_bus_req_t bus_req = '0;
	logic [7:0] bus_rdata;
	logic crystal_out_pin, osc_start, pins, up, lock, psel, aout;
	logic spike = 1'b0, tol = 1'b0, smode = 1'b0;
	logic pie = 1'b0, pea = 1'b0, pclk = 1'b0;
	logic [2:0] lvr = 3'h0;
	logic [15:0] crystal_out_pin_khz;
	pcp_freq_t freq;
	int bad_count = 0, total_checks = 0, cyc = 0;
	// Write and read rows; on a read d is the expected value
	pcp_row_t rows [25] = '{
		'{0, 10'h2f0, 8'h1f}, '{0, 10'h2f1, 8'h00}, '{0, 10'h2f2, 8'h03},
		'{0, 10'h2f3, 8'h80}, '{0, 10'h2fb, 8'h00}, '{0, 10'h2fa, 8'h00},
		'{1, 10'h3ff, 8'h55}, '{0, 10'h3ff, 8'h00}, '{1, 10'h2fb, 8'h11},
		'{0, 10'h2fb, 8'h01}, '{1, 10'h2f0, 8'h05}, '{1, 10'h2f1, 8'h03},
		'{1, 10'h2fa, 8'h80}, '{0, 10'h2f0, 8'h1f}, '{0, 10'h2f1, 8'h00},
		'{0, 10'h2fa, 8'h00}, '{1, 10'h2fb, 8'h26}, '{0, 10'h2fb, 8'h00},
		'{1, 10'h2f0, 8'h03}, '{1, 10'h2f2, 8'h00}, '{0, 10'h2f0, 8'h03},
		'{0, 10'h2f2, 8'h00}, '{1, 10'h2fc, 8'he3}, '{1, 10'h2fc, 8'h01},
		'{0, 10'h2fc, 8'h00}};
	pcp_top dut (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.crystal_in_pin(crystal_out_pin),
		.crystal_freq_khz(crystal_out_pin_khz),
		.pll_in_tolerance(tol),
		.special_mode(smode),
		.supply_lvr_status(lvr),
		.periodic_irq_enable(pie),
		.periodic_irq_ext_access(pea),
		.periodic_irq_clock(pclk),
		.osc_start(osc_start),
		.clock_monitor_en(),
		.crystal_pins_reserved(pins),
		.filtered_crystal_clock(),
		.osc_up_status(up),
		.pll_locked(lock),
		.pll_source_select(psel),
		.auto_clock_pin_out(aout),
		.freq(freq)
	);
	pcp_crystal_out_pin_model xm (
		.run(osc_start),
		.spike(spike),
		.crystal_in_pin(crystal_out_pin),
		.crystal_freq_khz(crystal_out_pin_khz)
	);
	always #5 core_clk = ~core_clk;
	task automatic final_report;
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Ceiling well above the thousand or so cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The strobe is left up so a read may follow with no gap
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus_req <= '0;
		@(negedge core_clk);
		chk(24'(bus_rdata), 24'(exp));
		@(posedge core_clk);
	endtask
	task automatic wait_lvl(ref logic s, input logic v);
		for (int i = 0; i < 1000 && s !== v; i++)
			@(negedge core_clk);
		chk(24'(s), 24'(v));
		@(posedge core_clk);
	endtask
	initial begin
		logic l0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		foreach (rows[i])
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			else
				rchk(rows[i].a, rows[i].d);
		// A write taken while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(ADDR_SYNTH, 8'h07);
		clk_en <= 1'b1;
		rchk(ADDR_SYNTH, 8'h03);
		repeat (3) @(negedge core_clk);
		chk(24'(freq.ref_khz), 24'(IRC_FREQ_KHZ));
		chk(freq.vco_khz, 24'(2 * IRC_FREQ_KHZ * 4));
		chk(freq.pll_khz, 24'(IRC_FREQ_KHZ * 2));
		@(posedge core_clk);
		tol <= 1'b1;
		wait_lvl(lock, 1'b1);
		@(negedge core_clk);
		chk(freq.pll_khz, 24'(2 * IRC_FREQ_KHZ * 4));
		chk(freq.bus_khz, 24'(IRC_FREQ_KHZ * 4));
		@(posedge core_clk);
		// Ratio 16000/4000 halved gives a filter value of 2
		wr(ADDR_REF_DIVIDER, 8'h01);
		wr(ADDR_OSC_CFG, 8'h82);
		bus_req <= '0;
		@(negedge core_clk);
		l0 = lock;
		@(negedge core_clk);
		chk(24'(l0 & lock), 24'h0);
		@(posedge core_clk);
		rchk(ADDR_OSC_CFG, 8'ha2);
		chk(24'(freq.ref_khz), 24'(crystal_out_pin_khz >> 1));
		wait_lvl(up, 1'b1);
		@(posedge crystal_out_pin);
		#12 spike = 1'b1;
		#10 spike = 1'b0;
		@(posedge core_clk);
		wait_lvl(up, 1'b0);
		wait_lvl(up, 1'b1);
		wr(ADDR_OSC_CFG, 8'h82);
		bus_req <= '0;
		repeat (3) @(posedge core_clk);
		chk(24'(up), 24'h0);
		lvr <= 3'h5;
		smode <= 1'b1;
		repeat (4) @(posedge core_clk);
		rchk(ADDR_TEST, 8'h28);
		wr(ADDR_TEST, 8'h01);
		rchk(ADDR_TEST, 8'h28);
		wr(ADDR_TEST, TEST_UNLOCK_KEY);
		wr(ADDR_TEST, 8'h3f);
		rchk(ADDR_TEST, 8'h29);
		pie <= 1'b1;
		pclk <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk(24'(aout), 24'h1);
		@(posedge core_clk);
		pclk <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk(24'(aout), 24'h0);
		@(posedge core_clk);
		pclk <= 1'b1;
		pea <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk(24'(aout), 24'h0);
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rchk(ADDR_OSC_CFG, 8'h00);
		chk(24'({pins, psel}), 24'h1);
		@(negedge core_clk);
		chk(freq.vco_khz, 24'(IRC_FREQ_KHZ * 64));
		chk(freq.pll_khz, 24'(IRC_FREQ_KHZ * 16));
		chk(freq.bus_khz, 24'(IRC_FREQ_KHZ * 8));
		final_report();
	end
endmodule
`default_nettype wire
